// [stop_ctl_pkg.sv]
// constants, types and operation summary of the stop-mode controller
// Operation
// - any stop depth stops the clocks of every peripheral module
// - debug-in-halt keeps debug clocks running, peripheral clocks still stop
// - clock-halt depth keeps every pin exactly as before stop
// - ram-kept depth captures and latches every pin before stop acts
// - full power-down depth drives every pin to its reset state
// - clock-halt depth keeps all ram and register contents
// - ram-kept wake resets registers, keeps ram, pins held until release
// - full power-down wake resets registers, ram lost, start as reset
// - clock-halt: clock generator standby, oscillator/reference by keep bits, unless debug enabled
// - deeper depths: clock generator fully off whatever the keep bits
// - timer, serial, two-wire halt in stop, reset after deeper wake
// - converter standby without conversions, reset after deeper wake
// - clock-halt depth: enabled keypad pins still wake the device
// - keypad wake disabled in deeper depths, reset after their wake
// - regulator standby in stop unless undervolt watch or debug enabled
// - deeper depth requested with debug enabled enters clock-halt depth
// - deeper depth requested with undervolt watch enters clock-halt depth
// - ram-kept wake sets recovery flag until release bit written one
// - clock-halt wake by interrupt resumes via vector, not reset
package stop_ctl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PIN_W = 8;
    localparam int KBI_W = 4;
    localparam int SYNC_W = 7;
    localparam int CTRL_W = 7;
    localparam int WAKE_W = 5;
    localparam int MODE_W = 3;
    localparam int CNT_W = 3;
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;
    localparam logic [3:0] WAKE_ADDR = 4'h8;
    localparam logic [1:0] DEPTH_FULL = 2'h1;
    localparam logic [1:0] DEPTH_RAM = 2'h2;
    localparam logic [1:0] DEPTH_LIGHT = 2'h3;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_LOST_BIT = 1;
    localparam int STAT_MODE_LSB = 4;
    localparam int WR_RELEASE_BIT = 0;
    localparam int WR_LOST_CLR_BIT = 1;
    localparam int SYNC_RTI = 0;
    localparam int SYNC_IRQ_N = 1;
    localparam int SYNC_RST_N = 2;
    localparam int SYNC_KBI_LSB = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h7E;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_RST_NS = 80;
    localparam int WAKE_RST_CYC =
        (WAKE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] WAKE_RST_LOAD = CNT_W'(WAKE_RST_CYC - 1);
    localparam logic [MODE_W-1:0] MODE_RUN = 3'h0;
    localparam logic [MODE_W-1:0] MODE_FULL = 3'h1;
    localparam logic [MODE_W-1:0] MODE_RAM = 3'h2;
    localparam logic [MODE_W-1:0] MODE_LIGHT = 3'h3;
    localparam logic [MODE_W-1:0] MODE_WAKE = 3'h4;
    typedef struct packed {
        logic kbi_en;
        logic keep_ref;
        logic keep_osc;
        logic uv_watch;
        logic dbg_en;
        logic [1:0] depth;
    } ctrl_type;
    localparam ctrl_type CTRL_RST = 7'h03;
    typedef struct packed {
        logic [PIN_W-1:0] out;
        logic [PIN_W-1:0] oe;
    } pin_type;
    localparam pin_type PIN_RST = 16'h0000;
    typedef struct packed {
        logic standby;
        logic off;
        logic osc_run;
        logic ref_run;
    } clkgen_type;
    localparam clkgen_type CLKGEN_RST = 4'h3;
    typedef struct packed {
        logic timer;
        logic serial;
        logic two_wire;
        logic analog;
        logic keypad;
    } periph_rst_type;
    typedef struct packed {
        logic debug;
        logic reset;
        logic keypad_wake_interrupt;
        logic irq;
        logic rti;
    } wake_src_type;
    typedef enum logic [2:0] {
        st_run, st_halt_light, st_halt_ram, st_halt_full, st_wake_rst
    } ctl_state_type;
endpackage : stop_ctl_pkg

// [sync_bank.sv]
// two-flop synchroniser bank for the asynchronous wake pins
`timescale 1ns/1ps
module sync_bank (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [stop_ctl_pkg::SYNC_W-1:0] din,
    output logic [stop_ctl_pkg::SYNC_W-1:0] dout
);
    typedef struct packed {
        logic [stop_ctl_pkg::SYNC_W-1:0] s1;
        logic [stop_ctl_pkg::SYNC_W-1:0] s2;
    } sync_state_type;
    localparam sync_state_type SYNC_STATE_RST = '{
        s1: stop_ctl_pkg::SYNC_RST,
        s2: stop_ctl_pkg::SYNC_RST
    };
    sync_state_type r;
    sync_state_type n;
    always_comb begin
        n = r;
        // first stage is read by the second stage only
        n.s1 = din;
        n.s2 = r.s1;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= SYNC_STATE_RST;
        end else begin
            r <= n;
        end
    end
    assign dout = r.s2;
endmodule : sync_bank

// [pin_hold.sv]
// pin drive stage: pass, capture-and-hold or force to reset state
`timescale 1ns/1ps
module pin_hold (
    input wire logic clk,
    input wire logic nrst,
    input wire stop_ctl_pkg::pin_type core,
    input wire logic capture,
    input wire logic hold,
    input wire logic force_default,
    output stop_ctl_pkg::pin_type pins
);
    typedef struct packed {
        stop_ctl_pkg::pin_type latch;
        stop_ctl_pkg::pin_type drive;
    } hold_state_type;
    localparam hold_state_type HOLD_RST = '{
        latch: stop_ctl_pkg::PIN_RST,
        drive: stop_ctl_pkg::PIN_RST
    };
    hold_state_type r;
    hold_state_type n;
    always_comb begin
        n = r;
        if (capture) begin
            n.latch = core;
        end
        if (force_default) begin
            n.drive = stop_ctl_pkg::PIN_RST;
        end else if (hold) begin
            // capture cycle drives the fresh value so no glitch appears
            n.drive = capture ? core : r.latch;
        end else begin
            n.drive = core;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= HOLD_RST;
        end else begin
            r <= n;
        end
    end
    assign pins = r.drive;
endmodule : pin_hold

// [stop_ctl.sv]
// stop-depth controller: gating, pin hold, clock and reset control
`timescale 1ns/1ps
module stop_ctl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [stop_ctl_pkg::ADDR_W-1:0] addr,
    input wire logic [stop_ctl_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [stop_ctl_pkg::DATA_W-1:0] rdata,
    input wire logic stop_exec,
    input wire logic bdm_wake,
    input wire logic rti_wake,
    input wire logic irq_pin_n,
    input wire logic reset_pin_n,
    input wire logic [stop_ctl_pkg::KBI_W-1:0] kbi_pin_n,
    input wire stop_ctl_pkg::pin_type core_pins,
    output stop_ctl_pkg::pin_type pins,
    output logic periph_clk_en,
    output logic debug_clk_en,
    output logic regulator_standby,
    output stop_ctl_pkg::clkgen_type clkgen_ctl,
    output logic analog_standby,
    output logic keypad_wake_armed,
    output logic ram_retain,
    output stop_ctl_pkg::periph_rst_type periph_rst,
    output logic sys_reset,
    output logic irq_resume,
    output logic in_stop,
    output logic deep_wake_recovery_flag
);

    ////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        stop_ctl_pkg::ctl_state_type st;
        stop_ctl_pkg::ctrl_type ctrl;
        stop_ctl_pkg::wake_src_type wake_src;
        logic dbg_lat;
        logic uv_lat;
        logic flag;
        logic ram_lost;
        logic hold;
        logic [stop_ctl_pkg::CNT_W-1:0] cnt;
        logic [stop_ctl_pkg::DATA_W-1:0] rdata;
        logic periph_clk_en;
        logic debug_clk_en;
        logic reg_standby;
        stop_ctl_pkg::clkgen_type clkgen;
        logic analog_standby;
        logic keypad_armed;
        logic ram_retain;
        stop_ctl_pkg::periph_rst_type prst;
        logic sys_reset;
        logic irq_resume;
        logic in_stop;
    } ctl_reg_type;

    localparam ctl_reg_type CTL_RST = '{
        st: stop_ctl_pkg::st_run,
        ctrl: stop_ctl_pkg::CTRL_RST,
        clkgen: stop_ctl_pkg::CLKGEN_RST,
        periph_clk_en: 1'b1,
        debug_clk_en: 1'b1,
        ram_retain: 1'b1,
        default: '0
    };

    ctl_reg_type r;
    ctl_reg_type n;

    logic [stop_ctl_pkg::SYNC_W-1:0] sync_q;
    logic s_rti;
    logic s_irq_n;
    logic s_rst_n;
    logic kbi_low;
    logic light_wake;
    logic deep_ram_wake;
    logic deep_full_wake;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_wake;
    logic pin_capture;
    logic pin_hold_lvl;
    logic pin_force;

    ////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic logic [1:0] eff_depth(
        input logic [1:0] req,
        input logic dbg,
        input logic uv
    );
        logic deep;
        deep = (req == stop_ctl_pkg::DEPTH_FULL) ||
               (req == stop_ctl_pkg::DEPTH_RAM);
        if (deep && dbg) begin
            eff_depth = stop_ctl_pkg::DEPTH_LIGHT;
        end else if (deep && uv) begin
            eff_depth = stop_ctl_pkg::DEPTH_LIGHT;
        end else if (deep) begin
            eff_depth = req;
        end else begin
            // the unused code falls back to the safest depth
            eff_depth = stop_ctl_pkg::DEPTH_LIGHT;
        end
    endfunction : eff_depth

    function automatic logic is_halt(
        input stop_ctl_pkg::ctl_state_type s
    );
        is_halt = (s == stop_ctl_pkg::st_halt_light) ||
                  (s == stop_ctl_pkg::st_halt_ram) ||
                  (s == stop_ctl_pkg::st_halt_full);
    endfunction : is_halt

    function automatic logic is_deep(
        input stop_ctl_pkg::ctl_state_type s
    );
        is_deep = (s == stop_ctl_pkg::st_halt_ram) ||
                  (s == stop_ctl_pkg::st_halt_full);
    endfunction : is_deep

    function automatic logic [stop_ctl_pkg::MODE_W-1:0] mode_code(
        input stop_ctl_pkg::ctl_state_type s
    );
        case (s)
            stop_ctl_pkg::st_halt_full: mode_code = stop_ctl_pkg::MODE_FULL;
            stop_ctl_pkg::st_halt_ram: mode_code = stop_ctl_pkg::MODE_RAM;
            stop_ctl_pkg::st_halt_light: mode_code = stop_ctl_pkg::MODE_LIGHT;
            stop_ctl_pkg::st_wake_rst: mode_code = stop_ctl_pkg::MODE_WAKE;
            default: mode_code = stop_ctl_pkg::MODE_RUN;
        endcase
    endfunction : mode_code

    ////////////////////////////////////////////////////////////////////
    // wake pins

    sync_bank u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({kbi_pin_n, reset_pin_n, irq_pin_n, rti_wake}),
        .dout(sync_q)
    );

    assign s_rti = sync_q[stop_ctl_pkg::SYNC_RTI];
    assign s_irq_n = sync_q[stop_ctl_pkg::SYNC_IRQ_N];
    assign s_rst_n = sync_q[stop_ctl_pkg::SYNC_RST_N];
    assign kbi_low = ~&sync_q[stop_ctl_pkg::SYNC_KBI_LSB +:
                              stop_ctl_pkg::KBI_W];

    // keypad pins wake only the light depth and only when armed
    assign light_wake = !s_irq_n || s_rti ||
                        (kbi_low && r.ctrl.kbi_en) ||
                        (bdm_wake && r.dbg_lat);
    assign deep_ram_wake = !s_rst_n || !s_irq_n || s_rti;
    assign deep_full_wake = !s_rst_n || !s_irq_n;

    ////////////////////////////////////////////////////////////////////
    // register port decode

    assign wr_ctrl = wr_en && (addr == stop_ctl_pkg::CTRL_ADDR);
    assign wr_stat = wr_en && (addr == stop_ctl_pkg::STAT_ADDR);
    assign wr_wake = wr_en && (addr == stop_ctl_pkg::WAKE_ADDR);

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [stop_ctl_pkg::DATA_W-1:0] rd;
        logic [1:0] depth;
        rd = '0;
        depth = stop_ctl_pkg::DEPTH_LIGHT;
        n = r;
        n.irq_resume = 1'b0;

        // software writes come first so hardware sets win below
        if (wr_ctrl) begin
            n.ctrl = stop_ctl_pkg::ctrl_type'(
                wdata[stop_ctl_pkg::CTRL_W-1:0]);
        end
        if (wr_stat && wdata[stop_ctl_pkg::WR_RELEASE_BIT]) begin
            n.flag = 1'b0;
            n.hold = 1'b0;
        end
        if (wr_stat && wdata[stop_ctl_pkg::WR_LOST_CLR_BIT]) begin
            n.ram_lost = 1'b0;
        end
        if (wr_wake) begin
            n.wake_src = r.wake_src &
                ~stop_ctl_pkg::wake_src_type'(
                    wdata[stop_ctl_pkg::WAKE_W-1:0]);
        end

        if (rd_en) begin
            case (addr)
                stop_ctl_pkg::CTRL_ADDR: begin
                    rd[stop_ctl_pkg::CTRL_W-1:0] = r.ctrl;
                end
                stop_ctl_pkg::STAT_ADDR: begin
                    rd[stop_ctl_pkg::STAT_FLAG_BIT] = r.flag;
                    rd[stop_ctl_pkg::STAT_LOST_BIT] = r.ram_lost;
                    rd[stop_ctl_pkg::STAT_MODE_LSB +:
                       stop_ctl_pkg::MODE_W] = mode_code(r.st);
                end
                stop_ctl_pkg::WAKE_ADDR: begin
                    rd[stop_ctl_pkg::WAKE_W-1:0] = r.wake_src;
                end
                default: begin
                    rd = '0;
                end
            endcase
        end
        // read data lives for exactly one cycle
        n.rdata = rd;

        case (r.st)
            stop_ctl_pkg::st_run: begin
                if (stop_exec) begin
                    // depth and overrides frozen at the stop instruction
                    n.dbg_lat = r.ctrl.dbg_en;
                    n.uv_lat = r.ctrl.uv_watch;
                    depth = eff_depth(r.ctrl.depth, r.ctrl.dbg_en,
                                      r.ctrl.uv_watch);
                    case (depth)
                        stop_ctl_pkg::DEPTH_FULL: begin
                            n.st = stop_ctl_pkg::st_halt_full;
                        end
                        stop_ctl_pkg::DEPTH_RAM: begin
                            n.st = stop_ctl_pkg::st_halt_ram;
                            n.hold = 1'b1;
                        end
                        default: begin
                            n.st = stop_ctl_pkg::st_halt_light;
                        end
                    endcase
                end
            end
            stop_ctl_pkg::st_halt_light: begin
                if (!s_rst_n) begin
                    n.st = stop_ctl_pkg::st_wake_rst;
                    n.cnt = stop_ctl_pkg::WAKE_RST_LOAD;
                    n.wake_src.reset = 1'b1;
                end else if (light_wake) begin
                    // registers kept, so resume through the vector
                    n.st = stop_ctl_pkg::st_run;
                    n.irq_resume = 1'b1;
                    n.wake_src.irq = n.wake_src.irq | !s_irq_n;
                    n.wake_src.rti = n.wake_src.rti | s_rti;
                    n.wake_src.keypad_wake_interrupt = n.wake_src.keypad_wake_interrupt |
                                     (kbi_low && r.ctrl.kbi_en);
                    n.wake_src.debug = n.wake_src.debug |
                                       (bdm_wake && r.dbg_lat);
                end
            end
            stop_ctl_pkg::st_halt_ram: begin
                if (deep_ram_wake) begin
                    n.st = stop_ctl_pkg::st_wake_rst;
                    n.cnt = stop_ctl_pkg::WAKE_RST_LOAD;
                    n.flag = 1'b1;
                    n.wake_src.reset = n.wake_src.reset | !s_rst_n;
                    n.wake_src.irq = n.wake_src.irq | !s_irq_n;
                    n.wake_src.rti = n.wake_src.rti | s_rti;
                end
            end
            stop_ctl_pkg::st_halt_full: begin
                if (deep_full_wake) begin
                    n.st = stop_ctl_pkg::st_wake_rst;
                    n.cnt = stop_ctl_pkg::WAKE_RST_LOAD;
                    n.ram_lost = 1'b1;
                    n.wake_src.reset = n.wake_src.reset | !s_rst_n;
                    n.wake_src.irq = n.wake_src.irq | !s_irq_n;
                end
            end
            stop_ctl_pkg::st_wake_rst: begin
                // control register returns to reset; flags survive
                n.ctrl = stop_ctl_pkg::CTRL_RST;
                n.dbg_lat = 1'b0;
                n.uv_lat = 1'b0;
                if (r.cnt == '0) begin
                    n.st = stop_ctl_pkg::st_run;
                end else begin
                    n.cnt = r.cnt - 1'b1;
                end
            end
            default: begin
                n.st = stop_ctl_pkg::st_run;
            end
        endcase

        // outputs follow the next state, so they act on the same edge
        n.in_stop = is_halt(n.st);
        n.periph_clk_en = !is_halt(n.st);
        n.debug_clk_en = !is_halt(n.st) || n.dbg_lat;
        n.reg_standby = is_halt(n.st) &&
                        !(n.dbg_lat || n.uv_lat);

        n.clkgen.standby = (n.st == stop_ctl_pkg::st_halt_light) &&
                           !n.dbg_lat;
        n.clkgen.off = is_deep(n.st);
        if (!is_halt(n.st)) begin
            n.clkgen.osc_run = 1'b1;
            n.clkgen.ref_run = 1'b1;
        end else if (n.st == stop_ctl_pkg::st_halt_light) begin
            // debug keeps the generator fully active
            n.clkgen.osc_run = n.ctrl.keep_osc || n.dbg_lat;
            n.clkgen.ref_run = n.ctrl.keep_ref || n.dbg_lat;
        end else begin
            n.clkgen.osc_run = 1'b0;
            n.clkgen.ref_run = 1'b0;
        end

        // standby also blocks any conversion start
        n.analog_standby = is_halt(n.st);
        n.keypad_armed = n.ctrl.kbi_en && !is_deep(n.st) &&
                         (n.st != stop_ctl_pkg::st_wake_rst);
        n.ram_retain = (n.st != stop_ctl_pkg::st_halt_full);

        n.sys_reset = (n.st == stop_ctl_pkg::st_wake_rst);
        n.prst.timer = n.sys_reset;
        n.prst.serial = n.sys_reset;
        n.prst.two_wire = n.sys_reset;
        n.prst.analog = n.sys_reset;
        n.prst.keypad = n.sys_reset;
    end

    ////////////////////////////////////////////////////////////////////
    // pin stage

    // the light depth holds too: port logic may not be fully frozen
    assign pin_capture = (r.st == stop_ctl_pkg::st_run) &&
                         ((n.st == stop_ctl_pkg::st_halt_ram) ||
                          (n.st == stop_ctl_pkg::st_halt_light));
    assign pin_hold_lvl = n.hold ||
                          (n.st == stop_ctl_pkg::st_halt_light);
    assign pin_force = (n.st == stop_ctl_pkg::st_halt_full);

    pin_hold u_pins (
        .clk(clk),
        .nrst(nrst),
        .core(core_pins),
        .capture(pin_capture),
        .hold(pin_hold_lvl),
        .force_default(pin_force),
        .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= CTL_RST;
        end else begin
            r <= n;
        end
    end

    assign rdata = r.rdata;
    assign periph_clk_en = r.periph_clk_en;
    assign debug_clk_en = r.debug_clk_en;
    assign regulator_standby = r.reg_standby;
    assign clkgen_ctl = r.clkgen;
    assign analog_standby = r.analog_standby;
    assign keypad_wake_armed = r.keypad_armed;
    assign ram_retain = r.ram_retain;
    assign periph_rst = r.prst;
    assign sys_reset = r.sys_reset;
    assign irq_resume = r.irq_resume;
    assign in_stop = r.in_stop;
    assign deep_wake_recovery_flag = r.flag;

endmodule : stop_ctl

// [stop_ctl_monitor.sv]
// port-level assertions for the stop controller
`timescale 1ns/1ps
module stop_ctl_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic stop_exec,
    input wire stop_ctl_pkg::pin_type pins,
    input wire logic periph_clk_en,
    input wire logic debug_clk_en,
    input wire logic regulator_standby,
    input wire stop_ctl_pkg::clkgen_type clkgen_ctl,
    input wire logic keypad_wake_armed,
    input wire logic ram_retain,
    input wire stop_ctl_pkg::periph_rst_type periph_rst,
    input wire logic sys_reset,
    input wire logic irq_resume,
    input wire logic in_stop,
    input wire logic deep_wake_recovery_flag
);
////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (!nrst);
clk_gate_a: assert property (in_stop |-> !periph_clk_en)
    else $error("peripheral clock runs in stop");
pin_hold_a: assert property (
    in_stop && $past(in_stop) |-> $stable(pins))
    else $error("pins moved in stop");
pin_default_a: assert property (
    in_stop && !ram_retain |-> pins == '0)
    else $error("pins not at default in full depth");
gen_off_a: assert property (
    clkgen_ctl.off |-> !clkgen_ctl.osc_run && !clkgen_ctl.ref_run)
    else $error("oscillator runs with generator off");
keypad_arm_a: assert property (
    keypad_wake_armed |-> !sys_reset && !clkgen_ctl.off)
    else $error("keypad armed in deep depth");
wake_len_a: assert property (
    $rose(sys_reset) |-> sys_reset[*4] ##1 !sys_reset)
    else $error("wake reset length wrong");
periph_reset_a: assert property (
    sys_reset |-> periph_rst == 5'h1F)
    else $error("peripherals not reset on wake");
regul_standby_a: assert property (
    regulator_standby |-> in_stop && !debug_clk_en)
    else $error("regulator standby out of place");
stop_entry_a: assert property (
    stop_exec && !in_stop && !sys_reset |=> in_stop)
    else $error("stop not entered");
vector_resume_a: assert property (
    irq_resume |-> $past(in_stop) && !sys_reset ##1 !irq_resume)
    else $error("resume pulse wrong");
flag_set_a: assert property (
    $rose(deep_wake_recovery_flag) |-> sys_reset)
    else $error("recovery flag set outside wake");
endmodule : stop_ctl_monitor

// [periph_model.sv]
// port logic model: runs on the peripheral clock, cleared by wake reset
`timescale 1ns/1ps
module periph_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic periph_clk_en,
    input wire stop_ctl_pkg::periph_rst_type periph_rst,
    output stop_ctl_pkg::pin_type core_pins
);
////////////////////////////////////////
logic [15:0] lfsr_r;
// changes every cycle the peripheral clock is enabled and the timer reset is low, so a missed hold shows at once
always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        lfsr_r <= 16'h00A5;
    end else if (periph_rst.timer) begin
        lfsr_r <= 16'h00A5;
    end else if (periph_clk_en) begin
        lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12]};
    end
end
assign core_pins = lfsr_r;
endmodule : periph_model

// [tb.sv]
// self-checking bench for the stop controller
`timescale 1ns/1ps
module tb;
logic clk = 0, nrst = 0, wr_en = 0, rd_en = 0, stop_exec = 0;
logic bdm_wake = 0, rti_wake = 0, irq_pin_n = 1, reset_pin_n = 1;
logic [3:0] addr = 4'h0, kbi_pin_n = 4'hF;
logic [7:0] wdata = 8'h00, rdata;
stop_ctl_pkg::pin_type core_pins, pins, cap;
stop_ctl_pkg::clkgen_type clkgen_ctl;
stop_ctl_pkg::periph_rst_type periph_rst;
logic periph_clk_en, debug_clk_en, regulator_standby, analog_standby;
logic keypad_wake_armed, ram_retain, sys_reset, irq_resume, in_stop;
logic deep_wake_recovery_flag;
int fail_count = 0, check_count = 0;
logic [31:0] seed = 32'h37;
stop_ctl dut (.clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .stop_exec, .bdm_wake, .rti_wake, .irq_pin_n, .reset_pin_n,
    .kbi_pin_n, .core_pins, .pins, .periph_clk_en, .debug_clk_en,
    .regulator_standby, .clkgen_ctl, .analog_standby, .keypad_wake_armed,
    .ram_retain, .periph_rst, .sys_reset, .irq_resume, .in_stop,
    .deep_wake_recovery_flag);
periph_model peer (.clk, .nrst, .periph_clk_en, .periph_rst, .core_pins);
always #10 clk = ~clk;
////////////////////////////////////////
task print_verdict();
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask : print_verdict
task chk(string n, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
        fail_count++;
        $display("[ERR] %s expected %h seen %h", n, e, s);
    end
endtask : chk
function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction : xs
task step(int n);
    repeat (n) @(posedge clk);
    #1;
endtask : step
// one strobe cycle; read data is settled on return
task bus(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    wr_en <= 0;
    rd_en <= 0;
    #1;
endtask : bus
task run_stop(logic [1:0] d, logic [31:0] r);
    logic dbg, uv, lt, full, kb, rs, rt, res;
    logic [7:0] wv;
    dbg = r[0] & r[1];
    uv = r[2] & r[3];
    lt = dbg | uv | (d == 2'h0) | (d == stop_ctl_pkg::DEPTH_LIGHT);
    full = !lt && (d == stop_ctl_pkg::DEPTH_FULL);
    // wake by keypad where armed and r[7] set, else reset pin, periodic wake or irq
    kb = lt & r[6] & r[7];
    rs = !kb && (r[11:10] == 2'h2);
    rt = !kb && !full && (r[11:10] == 2'h1);
    res = lt && !rs;
    wv = {1'b0, r[6:4], uv, dbg, d};
    bus(1, stop_ctl_pkg::CTRL_ADDR, wv);
    @(posedge clk);
    stop_exec <= 1;
    #1 cap = full ? 16'h0000 : core_pins;
    @(posedge clk);
    stop_exec <= 0;
    #1;
    chk("clk_en", {periph_clk_en, debug_clk_en}, {1'b0, dbg});
    chk("pins", pins, cap);
    chk("ram", ram_retain, !full);
    chk("regul", regulator_standby, !(dbg | uv));
    chk("analog", analog_standby, 1'b1);
    chk("kbd", keypad_wake_armed, lt & r[6]);
    chk("gen", clkgen_ctl,
        lt ? {!dbg, 1'b0, r[4] | dbg, r[5] | dbg} : 4'h4);
    step(2);
    chk("hold", pins, cap);
    @(posedge clk);
    // keypad wake only where the depth leaves it armed
    if (kb) kbi_pin_n[r[9:8]] <= 1'b0;
    else if (rs) reset_pin_n <= 1'b0;
    else if (rt) rti_wake <= 1'b1;
    else irq_pin_n <= 1'b0;
    for (int k = 0; k < 8 && in_stop; k++) step(1);
    chk("wake", {in_stop, irq_resume, sys_reset},
        res ? 3'h2 : 3'h1);
    if (!res) chk("prst", periph_rst, 5'h1F);
    irq_pin_n <= 1;
    reset_pin_n <= 1;
    rti_wake <= 0;
    kbi_pin_n <= 4'hF;
    step(6);
    bus(0, stop_ctl_pkg::CTRL_ADDR, 8'h00);
    chk("ctrl", rdata, res ? wv : 8'h03);
    bus(0, stop_ctl_pkg::STAT_ADDR, 8'h00);
    chk("status", rdata, lt ? 8'h00 : full ? 8'h02 : 8'h01);
    bus(0, stop_ctl_pkg::WAKE_ADDR, 8'h00);
    chk("src", rdata, {4'h0, rs, kb, !(kb | rs | rt), rt});
    bus(1, stop_ctl_pkg::WAKE_ADDR, 8'h1F);
    if (!lt && !full) chk("latched", pins, cap);
    bus(1, stop_ctl_pkg::STAT_ADDR, 8'h03);
    cap = core_pins;
    step(1);
    chk("follow", pins, cap);
    chk("flag", deep_wake_recovery_flag, 1'b0);
endtask : run_stop
initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    step(3);
    chk("gen_rst", clkgen_ctl, 4'h3);
    bus(0, stop_ctl_pkg::CTRL_ADDR, 8'h00);
    chk("ctrl_rst", rdata, 8'h03);
    bus(0, 4'hC, 8'h00);
    chk("unmapped", rdata, 8'h00);
    for (int i = 0; i < 16; i++) run_stop(i[1:0], xs());
    print_verdict();
end
// the whole sequence needs well under a thousand cycles
initial begin
    #100000;
    fail_count++;
    print_verdict();
end
endmodule : tb
bind stop_ctl stop_ctl_monitor mon (.clk, .nrst, .stop_exec, .pins,
    .periph_clk_en, .debug_clk_en, .regulator_standby, .clkgen_ctl,
    .keypad_wake_armed, .ram_retain, .periph_rst, .sys_reset, .irq_resume,
    .in_stop, .deep_wake_recovery_flag);
